/* File: logic/ranging_result_engine.sv */
// ranging exchange control, result capture, filter and readout registers
// ==========================================
// Contract
// - role byte 0x01 initiator, 0x00 responder
// - automatic receive/transmit turnaround in both roles
// - 24-bit result in three bytes, initiator
// - window length from 0x91E, 8..255
// - find peak strength in window
// - reject samples below peak minus offset
// - average kept samples as filtered result
// - bit 6 of 0x923 clears window
// - bit 1 of 0x97F freezes result
// - select 00 raw, 01 filtered
// - report single exchange strength on initiator
// - bit 15 interrupt becomes overhear done
// - overhear done on heard reply
// - 0x927 steers heard address bytes
// - overhear measures request-to-reply time difference
// - responder compares 8/16/24/32 address bits
// - calibration at 0x92C/0x92D applied to measurement
`timescale 1ns/1ps
`include "ranging_cfg.svh"
module ranging_result_engine (
  input  wire logic        sys_clk,          // 10 MHz clock
  input  wire logic        reset_n,          // async reset
  input  wire logic        cmd_valid,        // command strobe
  input  wire logic [7:0]  cmd_opcode,       // command opcode
  input  wire logic [15:0] cmd_arg,          // byte or period count
  input  wire logic        reg_wr,           // register write strobe
  input  wire logic        reg_rd,           // register read strobe
  input  wire logic [15:0] reg_addr,         // register address
  input  wire logic [7:0]  reg_wdata,        // write data
  output logic [7:0]       reg_rdata,        // read data
  output logic             reg_rvalid,       // read data valid
  input  wire logic        period_tick,      // one period base elapsed
  input  wire logic        tx_done,          // modem frame sent
  input  wire logic        req_heard,        // request received
  input  wire logic [31:0] req_addr,         // address in request
  input  wire logic        resp_heard,       // reply received
  input  wire logic [7:0]  resp_rssi,        // reply strength
  input  wire logic        preamble_seen_irq, // modem preamble event
  output logic             radio_tx_en,      // modem transmit
  output logic             radio_rx_en,      // modem receive
  output logic             is_initiator,     // role
  output logic             overhear_on,      // overhear mode
  output logic             crystal_idle,     // crystal standby held
  output logic             modem_mem_clk_en, // result memory clock
  output logic [7:0]       ranging_strength, // strength of last reply heard as initiator
  output logic             initiator_result_ready_irq,    // pulse
  output logic             initiator_timeout_irq,         // pulse
  output logic             responder_reply_sent_irq,      // pulse
  output logic             responder_request_dropped_irq, // pulse
  output logic             overhear_done_irq,             // pulse
  output logic             irq_bit15                      // shared bit
);
  ranging_pkg::xchg_state_t state;
  logic [15:0] period_count, tmo_cnt, cal;
  logic [31:0] rsp_addr, heard_addr, addr_mask;
  logic [23:0] tnow, t0, raw_last, res_q, filtered, raw_hold, filt_hold;
  logic [7:0]  win_len, clr_keep, sel_reg, asel_reg, cmp_reg, rej_ofs, hold_reg;
  logic        freeze, addr_ok, timeout, raw_new, feed, filt_busy, filt_done;
  logic        cmd_role, cont, clr_pulse;
  logic [1:0]  cmp_w;

  // ==========================================
  // commands and configuration
  assign cmd_role  = cmd_valid && cmd_opcode == `OP_ROLE;
  assign cont      = (period_count == `PERIOD_CONT);
  assign freeze    = hold_reg[`HOLD_BIT];
  assign modem_mem_clk_en = freeze;
  assign clr_pulse = reg_wr && reg_addr == `A_WIN_CLR && reg_wdata[`CLR_BIT];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      is_initiator <= 1'b0;
      overhear_on  <= 1'b0;
      crystal_idle <= 1'b0;
      period_count <= 16'h0;
    end
    else if (cmd_valid)
    begin
      case (cmd_opcode)
        `OP_ROLE:     is_initiator <= (cmd_arg[7:0] == `ARG_INITIATOR);
        `OP_OVERHEAR: overhear_on  <= (cmd_arg[7:0] == `ARG_ON);
        `OP_STANDBY:  crystal_idle <= cmd_arg[0];
        `OP_RX_START: period_count <= cmd_arg;
        `OP_TX_START: period_count <= cmd_arg;
        default:      crystal_idle <= crystal_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      win_len  <= `WIN_LEN_RST;
      clr_keep <= 8'h00;
      sel_reg  <= 8'h00;
      asel_reg <= 8'h00;
      cmp_reg  <= 8'h00;
      rej_ofs  <= `REJ_OFS_RST;
      hold_reg <= 8'h00;
      rsp_addr <= 32'h0;
      cal      <= 16'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `A_WIN_LEN:   win_len  <= reg_wdata;
        `A_WIN_CLR:   clr_keep <= reg_wdata & ~(8'h01 << `CLR_BIT);
        `A_RES_SEL:   sel_reg  <= reg_wdata;
        `A_ADDR_SEL:  asel_reg <= reg_wdata;
        `A_CMP_WIDTH: cmp_reg  <= reg_wdata;
        `A_REJ_OFS:   rej_ofs  <= reg_wdata;
        `A_HOLD:      hold_reg <= reg_wdata;
        `A_RSP_ADDR3: rsp_addr[31:24] <= reg_wdata;
        `A_RSP_ADDR2: rsp_addr[23:16] <= reg_wdata;
        `A_RSP_ADDR1: rsp_addr[15:8]  <= reg_wdata;
        `A_RSP_ADDR0: rsp_addr[7:0]   <= reg_wdata;
        `A_CAL_HI:    cal[15:8] <= reg_wdata;
        `A_CAL_LO:    cal[7:0]  <= reg_wdata;
        default:      cal <= cal;
      endcase
    end
  end

  // ==========================================
  // exchange sequencing
  assign cmp_w     = cmp_reg[`CMP_MSB:`CMP_LSB];
  assign addr_mask = {{8{cmp_w == 2'h3}}, {8{cmp_w >= 2'h2}},
                      {8{cmp_w >= 2'h1}}, 8'hff};
  assign addr_ok   = ((req_addr ^ rsp_addr) & addr_mask) == 32'h0;
  assign timeout   = !cont && period_tick && (tmo_cnt + 16'h1 >= period_count);
  assign radio_tx_en = (state == ranging_pkg::st_tx_req)
                    || (state == ranging_pkg::st_tx_reply);
  assign radio_rx_en = (state == ranging_pkg::st_wait_resp)
                    || (state == ranging_pkg::st_wait_req)
                    || (state == ranging_pkg::st_overhear);

  // free-running timebase; differences are taken modulo 2^24
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tnow <= 24'h0;
    else
      tnow <= tnow + 24'h1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tmo_cnt <= 16'h0;
    else if (!radio_rx_en || req_heard || resp_heard)
      tmo_cnt <= 16'h0;
    else if (period_tick)
      tmo_cnt <= tmo_cnt + 16'h1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state    <= ranging_pkg::st_idle;
      t0       <= 24'h0;
      raw_new  <= 1'b0;
      raw_last <= 24'h0;
      heard_addr <= 32'h0;
      ranging_strength <= 8'h00;
      initiator_timeout_irq         <= 1'b0;
      responder_reply_sent_irq      <= 1'b0;
      responder_request_dropped_irq <= 1'b0;
    end
    else
    begin
      raw_new <= 1'b0;
      initiator_timeout_irq         <= 1'b0;
      responder_reply_sent_irq      <= 1'b0;
      responder_request_dropped_irq <= 1'b0;
      case (state)
        ranging_pkg::st_idle:
          if (cmd_valid && cmd_opcode == `OP_TX_START && is_initiator && !overhear_on)
            state <= ranging_pkg::st_tx_req;
          else if (cmd_valid && cmd_opcode == `OP_RX_START)
            state <= overhear_on ? ranging_pkg::st_overhear : ranging_pkg::st_wait_req;
        ranging_pkg::st_tx_req:
          if (tx_done)
          begin
            t0    <= tnow;
            state <= ranging_pkg::st_wait_resp;
          end
        ranging_pkg::st_wait_resp:
          if (resp_heard)
          begin
            raw_last <= tnow - t0 - {8'h00, cal};
            raw_new  <= 1'b1;
            ranging_strength <= resp_rssi;
            state    <= ranging_pkg::st_idle;
          end
          else if (timeout)
          begin
            initiator_timeout_irq <= 1'b1;
            state <= ranging_pkg::st_idle;
          end
        ranging_pkg::st_wait_req:
          if (req_heard && addr_ok)
            state <= ranging_pkg::st_tx_reply;
          else if (req_heard)
          begin
            responder_request_dropped_irq <= 1'b1;
            if (!cont)
              state <= ranging_pkg::st_idle;
          end
          else if (timeout)
            state <= ranging_pkg::st_idle;
        ranging_pkg::st_tx_reply:
          if (tx_done)
          begin
            responder_reply_sent_irq <= 1'b1;
            state <= cont ? ranging_pkg::st_wait_req : ranging_pkg::st_idle;
          end
        ranging_pkg::st_overhear:
          if (req_heard)
          begin
            t0         <= tnow;
            heard_addr <= req_addr;
          end
          else if (resp_heard)
          begin
            raw_last <= tnow - t0 - {8'h00, cal};
            raw_new  <= 1'b1;
          end
          else if (timeout)
            state <= ranging_pkg::st_idle;
        default: state <= ranging_pkg::st_idle;
      endcase
      if (cmd_valid && cmd_opcode == `OP_STANDBY)
        state <= ranging_pkg::st_idle;
    end
  end

  // ==========================================
  // filter, result view and ready events
  // a sample that lands while a scan runs is not filtered; the raw view still updates
  assign feed = raw_new && !freeze && !filt_busy;

  ranging_window_filter u_filter (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .clear         (clr_pulse),
    .sample_valid  (feed),
    .sample        (raw_last),
    .sample_rssi   (ranging_strength),
    .window_len    (win_len),
    .reject_offset (rej_ofs),
    .busy          (filt_busy),
    .done          (filt_done),
    .filtered      (filtered)
  );

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      raw_hold  <= 24'h0;
      filt_hold <= 24'h0;
    end
    else if (!freeze)
    begin
      raw_hold  <= raw_last;
      filt_hold <= filtered;
    end
  end

  // select sits after the hold: the host freezes first, then picks the view
  assign res_q = (sel_reg[`SEL_MSB:`SEL_LSB] == `SEL_FILT) ? filt_hold : raw_hold;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      initiator_result_ready_irq <= 1'b0;
      overhear_done_irq          <= 1'b0;
    end
    else
    begin
      initiator_result_ready_irq <= is_initiator && !overhear_on
                                 && (filt_done || (raw_new && !feed));
      overhear_done_irq <= overhear_on && (filt_done || (raw_new && !feed));
    end
  end

  assign irq_bit15 = overhear_on ? overhear_done_irq : preamble_seen_irq;

  // ==========================================
  // register read port
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `A_WIN_LEN:   reg_rdata <= win_len;
          `A_WIN_CLR:   reg_rdata <= clr_keep;
          `A_RES_SEL:   reg_rdata <= sel_reg;
          `A_ADDR_SEL:  reg_rdata <= asel_reg;
          `A_CMP_WIDTH: reg_rdata <= cmp_reg;
          `A_REJ_OFS:   reg_rdata <= rej_ofs;
          `A_HOLD:      reg_rdata <= hold_reg;
          `A_RSP_ADDR3: reg_rdata <= rsp_addr[31:24];
          `A_RSP_ADDR2: reg_rdata <= rsp_addr[23:16];
          `A_RSP_ADDR1: reg_rdata <= rsp_addr[15:8];
          `A_RSP_ADDR0: reg_rdata <= rsp_addr[7:0];
          `A_CAL_HI:    reg_rdata <= cal[15:8];
          `A_CAL_LO:    reg_rdata <= cal[7:0];
          `A_HEARD_LO:  reg_rdata <= asel_reg[0] ? heard_addr[23:16] : heard_addr[7:0];
          `A_HEARD_HI:  reg_rdata <= asel_reg[0] ? heard_addr[31:24] : heard_addr[15:8];
          `A_RES_UPPER: reg_rdata <= res_q[23:16];
          `A_RES_MIDDLE: reg_rdata <= res_q[15:8];
          `A_RES_LOWER: reg_rdata <= res_q[7:0];
          default:      reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================
  // checks
  sequence s_req_match;
    state == ranging_pkg::st_wait_req && req_heard && addr_ok;
  endsequence
  sequence s_reply_out;
    radio_tx_en && state == ranging_pkg::st_tx_reply;
  endsequence

  property p_role;
    @(posedge sys_clk) disable iff (!reset_n)
      cmd_role |=> (is_initiator == ($past(cmd_arg[7:0]) == `ARG_INITIATOR));
  endproperty
  a_role: assert property (p_role)
    else $error("role not taken from command");

  property p_resp_turn;
    @(posedge sys_clk) disable iff (!reset_n) s_req_match |=> s_reply_out;
  endproperty
  a_resp_turn: assert property (p_resp_turn)
    else $error("responder did not turn to transmit");

  property p_init_turn;
    @(posedge sys_clk) disable iff (!reset_n)
      (state == ranging_pkg::st_tx_req && tx_done) |=> (radio_rx_en && !radio_tx_en);
  endproperty
  a_init_turn: assert property (p_init_turn)
    else $error("initiator did not turn to receive");

  property p_drop;
    @(posedge sys_clk) disable iff (!reset_n)
      (state == ranging_pkg::st_wait_req && req_heard && !addr_ok)
        |=> responder_request_dropped_irq && !radio_tx_en;
  endproperty
  a_drop: assert property (p_drop)
    else $error("mismatched request not dropped");

  property p_freeze;
    @(posedge sys_clk) disable iff (!reset_n)
      (freeze ##1 freeze) |-> $stable({raw_hold, filt_hold});
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen result moved");

  property p_raw_view;
    @(posedge sys_clk) disable iff (!reset_n)
      (!freeze && sel_reg[`SEL_MSB:`SEL_LSB] == `SEL_RAW)
        ##1 (sel_reg[`SEL_MSB:`SEL_LSB] == `SEL_RAW) |-> (res_q == $past(raw_last));
  endproperty
  a_raw_view: assert property (p_raw_view)
    else $error("raw view not selected");

  property p_bit15;
    @(posedge sys_clk) disable iff (!reset_n)
      overhear_on |-> (irq_bit15 == overhear_done_irq);
  endproperty
  a_bit15: assert property (p_bit15)
    else $error("bit 15 not overhear done");

  property p_strength;
    @(posedge sys_clk) disable iff (!reset_n)
      (state == ranging_pkg::st_wait_resp && resp_heard)
        |=> (ranging_strength == $past(resp_rssi)) ##0 raw_new;
  endproperty
  a_strength: assert property (p_strength)
    else $error("reply strength not captured");

  property p_ready;
    @(posedge sys_clk) disable iff (!reset_n)
      (raw_new && is_initiator && !overhear_on && !feed) |=> initiator_result_ready_irq;
  endproperty
  a_ready: assert property (p_ready)
    else $error("result ready not raised");
endmodule // ranging_result_engine

/* File: logic/ranging_cfg.svh */
// constants for the ranging result engine
`ifndef RANGING_CFG_SVH
`define RANGING_CFG_SVH
// command opcodes and argument values
`define OP_ROLE        8'ha3
`define OP_OVERHEAR    8'h9a
`define OP_STANDBY     8'h80
`define OP_RX_START    8'h82
`define OP_TX_START    8'h83
`define ARG_INITIATOR  8'h01
`define ARG_ON         8'h01
`define PERIOD_CONT    16'hffff
// register addresses
`define A_RSP_ADDR3    16'h0916
`define A_RSP_ADDR2    16'h0917
`define A_RSP_ADDR1    16'h0918
`define A_RSP_ADDR0    16'h0919
`define A_WIN_LEN      16'h091e
`define A_WIN_CLR      16'h0923
`define A_RES_SEL      16'h0924
`define A_ADDR_SEL     16'h0927
`define A_CAL_HI       16'h092c
`define A_CAL_LO       16'h092d
`define A_CMP_WIDTH    16'h0931
`define A_REJ_OFS      16'h0953
`define A_HEARD_HI     16'h095f
`define A_HEARD_LO     16'h0960
`define A_RES_UPPER    16'h0961
`define A_RES_MIDDLE   16'h0962
`define A_RES_LOWER    16'h0963
`define A_HOLD         16'h097f
// fields
`define CLR_BIT        6
`define HOLD_BIT       1
`define SEL_MSB        5
`define SEL_LSB        4
`define CMP_MSB        7
`define CMP_LSB        6
`define SEL_RAW        2'h0
`define SEL_FILT       2'h1
// reset values and limits
`define REJ_OFS_RST    8'h24
`define WIN_LEN_RST    8'h08
`define WIN_MIN        8'h08
`define FILT_DEPTH     255
`define FILT_LAST      8'hfe
`endif

/* File: logic/ranging_pkg.sv */
// types shared by the ranging result engine
package ranging_pkg;
  typedef enum logic [2:0] {
    st_idle, st_tx_req, st_wait_resp, st_wait_req, st_tx_reply, st_overhear
  } xchg_state_t;
  typedef enum logic [1:0] {
    fs_idle, fs_scan_max, fs_scan_sum, fs_finish
  } filt_state_t;
endpackage

/* File: logic/ranging_window_filter.sv */
// sliding-window strength filter for raw ranging samples
`timescale 1ns/1ps
`include "ranging_cfg.svh"
module ranging_window_filter (
  input  wire logic        sys_clk,       // system clock
  input  wire logic        reset_n,       // async reset
  input  wire logic        clear,         // drop all held samples
  input  wire logic        sample_valid,  // new raw sample
  input  wire logic [23:0] sample,        // raw result
  input  wire logic [7:0]  sample_rssi,   // strength of sample
  input  wire logic [7:0]  window_len,    // requested window
  input  wire logic [7:0]  reject_offset, // dB below peak
  output logic             busy,          // scan running
  output logic             done,          // filtered updated
  output logic [23:0]      filtered       // filtered average
);
  logic [23:0] val_mem [`FILT_DEPTH];
  logic [7:0]  rssi_mem [`FILT_DEPTH];
  logic [7:0]  wr_ptr, fill, idx, newest, left, cnt, peak, taken;
  logic [7:0]  win_eff, next_fill, n_use;
  logic [31:0] sum;
  ranging_pkg::filt_state_t state;
  logic take;

  // ==========================================
  // window bookkeeping
  assign win_eff   = (window_len < `WIN_MIN) ? `WIN_MIN : window_len;
  assign next_fill = (fill == 8'(`FILT_DEPTH)) ? fill : fill + 8'h01;
  assign n_use     = (next_fill < win_eff) ? next_fill : win_eff;
  assign busy      = (state != ranging_pkg::fs_idle);
  assign take      = sample_valid && !busy && !clear;

  genvar g;
  generate
    for (g = 0; g < `FILT_DEPTH; g++)
    begin : g_slot
      always_ff @(posedge sys_clk)
      begin
        if (take && wr_ptr == 8'(g))
        begin
          val_mem[g]  <= sample;
          rssi_mem[g] <= sample_rssi;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= 8'h00;
      fill   <= 8'h00;
    end
    else if (clear)
    begin
      wr_ptr <= 8'h00;
      fill   <= 8'h00;
    end
    else if (take)
    begin
      wr_ptr <= (wr_ptr == `FILT_LAST) ? 8'h00 : wr_ptr + 8'h01;
      fill   <= next_fill;
    end
  end

  // ==========================================
  // two passes: peak strength, then sum of kept samples
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ranging_pkg::fs_idle;
      {idx, newest, left, cnt, peak, taken} <= '0;
      sum      <= 32'h0;
      done     <= 1'b0;
      filtered <= 24'h0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ranging_pkg::fs_idle:
          if (take)
          begin
            idx    <= wr_ptr;
            newest <= wr_ptr;
            left   <= n_use;
            cnt    <= n_use;
            peak   <= 8'h00;
            state  <= ranging_pkg::fs_scan_max;
          end
        ranging_pkg::fs_scan_max:
        begin
          if (rssi_mem[idx] > peak)
            peak <= rssi_mem[idx];
          idx  <= (idx == 8'h00) ? `FILT_LAST : idx - 8'h01;
          left <= left - 8'h01;
          if (left == 8'h01)
          begin
            idx   <= newest;
            left  <= cnt;
            sum   <= 32'h0;
            taken <= 8'h00;
            state <= ranging_pkg::fs_scan_sum;
          end
        end
        ranging_pkg::fs_scan_sum:
        begin
          if ({1'b0, rssi_mem[idx]} + {1'b0, reject_offset} >= {1'b0, peak})
          begin
            sum   <= sum + {8'h00, val_mem[idx]};
            taken <= taken + 8'h01;
          end
          idx  <= (idx == 8'h00) ? `FILT_LAST : idx - 8'h01;
          left <= left - 8'h01;
          if (left == 8'h01)
            state <= ranging_pkg::fs_finish;
        end
        ranging_pkg::fs_finish:
        begin
          filtered <= 24'(sum / {24'h0, taken});
          done     <= 1'b1;
          state    <= ranging_pkg::fs_idle;
        end
        default: state <= ranging_pkg::fs_idle;
      endcase
      if (clear)
        state <= ranging_pkg::fs_idle;
    end
  end

  property p_clear_empties;
    @(posedge sys_clk) disable iff (!reset_n) clear |=> (fill == 8'h00);
  endproperty
  a_clear_empties: assert property (p_clear_empties)
    else $error("window not emptied by clear");
endmodule // ranging_window_filter

/* File: test/modem_model.sv */
// behavioural modem on the far side of the ranging engine
`timescale 1ns/1ps
module modem_model (
  input  wire logic        sys_clk,      // clock
  input  wire logic        radio_tx_en,  // send
  input  wire logic        radio_rx_en,  // listen
  input  wire logic        is_initiator, // role
  input  wire logic        overhear_on,  // overhear
  input  wire logic [31:0] air_addr,     // address on air
  output logic             tx_done,      // frame sent
  output logic             req_heard,    // request in
  output logic [31:0]      req_addr,     // its address
  output logic             resp_heard,   // reply in
  output logic [7:0]       resp_rssi     // reply strength
);
  logic [3:0] tx_age;
  logic [3:0] rx_age;
  // unqualified lines carry garbage, not the last value
  assign req_addr = req_heard ? air_addr : ~air_addr;
  assign resp_rssi = resp_heard ? 8'h5a : 8'ha5;
  always_ff @(posedge sys_clk)
  begin
    tx_age <= (radio_tx_en && tx_age != 4'hf) ? tx_age + 4'h1 : {4{radio_tx_en}};
    rx_age <= (radio_rx_en && rx_age != 4'hf) ? rx_age + 4'h1 : {4{radio_rx_en}};
  end
  assign tx_done = (tx_age == 4'h3);
  assign req_heard = !is_initiator && (rx_age == 4'h4);
  assign resp_heard = (is_initiator || overhear_on) && (rx_age == 4'h9);
endmodule // modem_model

/* File: test/test_ranging_result_engine.sv */
// self-checking bench for the ranging result engine
`timescale 1ns/1ps
module test_ranging_result_engine;
  // ==========================================
  // signals
  logic sys_clk, reset_n, cmd_valid, reg_wr, reg_rd, period_tick, preamble_seen_irq;
  logic reg_rvalid, radio_tx_en, radio_rx_en, is_initiator, overhear_on, crystal_idle;
  logic modem_mem_clk_en, initiator_result_ready_irq, initiator_timeout_irq, irq_bit15;
  logic responder_reply_sent_irq, responder_request_dropped_irq, overhear_done_irq;
  logic tx_done, req_heard, resp_heard;
  logic [7:0] cmd_opcode, reg_wdata, reg_rdata, ranging_strength, resp_rssi, rdv;
  logic [15:0] cmd_arg, reg_addr;
  logic [31:0] req_addr, air_addr;
  logic [23:0] raw, filt;
  int checks, n_mismatch, cycles;
  int cnt[5];
  ranging_result_engine dut_u (.*);
  modem_model modem_u (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cnt[0] <= cnt[0] + int'(initiator_result_ready_irq);
    cnt[1] <= cnt[1] + int'(responder_reply_sent_irq);
    cnt[2] <= cnt[2] + int'(responder_request_dropped_irq);
    cnt[3] <= cnt[3] + int'(overhear_done_irq);
    cnt[4] <= cnt[4] + int'(initiator_timeout_irq);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================
  // bus tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    cmd_arg <= arg;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e, input bit cmp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
    if (cmp)
      chk({reg_rvalid, 15'h0, rdv}, {1'b1, 15'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic rd_res(output logic [23:0] r);
    rc(16'h0961, 8'h00, 0);
    r[23:16] = rdv;
    rc(16'h0962, 8'h00, 0);
    r[15:8] = rdv;
    rc(16'h0963, 8'h00, 0);
    r[7:0] = rdv;
  endtask
  task automatic wait_irq(input int k);
    int n0;
    n0 = cnt[k];
    repeat (400) if (cnt[k] == n0) @(posedge sys_clk);
    chk(24'(cnt[k] > n0), 24'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic s_regs();
    rc(16'h091e, 8'h08, 1);
    rc(16'h0953, 8'h24, 1);
    wr(16'h0923, 8'h40);
    rc(16'h0923, 8'h00, 1);
    wr(16'h0961, 8'hff);
    rc(16'h0961, 8'h00, 1);
  endtask
  task automatic s_initiator();
    cmd(8'ha3, 16'h0001);
    chk({23'h0, is_initiator}, 24'h1);
    period_tick <= 1'b1;
    cmd(8'h83, 16'h0001);
    wait_irq(4);
    period_tick <= 1'b0;
    cmd(8'h83, 16'hffff);
    wait_irq(0);
    chk({16'h0, ranging_strength}, 24'h5a);
    // second sample comes out 2 shorter, so the mean differs from the raw view
    wr(16'h092d, 8'h02);
    cmd(8'h83, 16'hffff);
    wait_irq(0);
    cmd(8'h80, 16'h0001);
    chk({23'h0, crystal_idle}, 24'h1);
    wr(16'h097f, 8'h02);
    chk({23'h0, modem_mem_clk_en}, 24'h1);
    wr(16'h0924, 8'h10);
    rd_res(filt);
    wr(16'h0924, 8'h00);
    rd_res(raw);
    chk(filt, 24'h9);
    chk(raw, 24'h8);
    // distance in cm at 1 MHz bandwidth
    chk(24'(raw * 24'h3a98 / 24'h1000), 24'h1d);
    cmd(8'h80, 16'h0000);
    wr(16'h097f, 8'h00);
  endtask
  task automatic s_responder();
    cmd(8'ha3, 16'h0000);
    chk({23'h0, is_initiator}, 24'h0);
    air_addr <= 32'h12345600;
    cmd(8'h82, 16'hffff);
    wait_irq(1);
    cmd(8'h80, 16'h0000);
    wr(16'h0931, 8'hc0);
    cmd(8'h82, 16'hffff);
    wait_irq(2);
    cmd(8'h80, 16'h0000);
  endtask
  task automatic s_overhear();
    cmd(8'h9a, 16'h0001);
    preamble_seen_irq <= 1'b1;
    air_addr <= 32'h44332211;
    cmd(8'h82, 16'hffff);
    chk({23'h0, irq_bit15}, 24'h0);
    wait_irq(3);
    cmd(8'h80, 16'h0001);
    wr(16'h097f, 8'h02);
    rd_res(raw);
    chk(raw, 24'h3);
    rc(16'h0960, 8'h11, 1);
    rc(16'h095f, 8'h22, 1);
    wr(16'h0927, 8'h01);
    rc(16'h0960, 8'h33, 1);
    rc(16'h095f, 8'h44, 1);
    cmd(8'h80, 16'h0000);
    cmd(8'h9a, 16'h0000);
    chk({22'h0, overhear_on, irq_bit15}, 24'h1);
  endtask
  initial
  begin
    {reset_n, cmd_valid, reg_wr, reg_rd, period_tick, preamble_seen_irq} = 6'h00;
    {cmd_opcode, cmd_arg, reg_addr, reg_wdata, air_addr} = 80'h0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    s_regs();
    s_initiator();
    s_responder();
    s_overhear();
    give_verdict();
  end
endmodule // test_ranging_result_engine
